// [verification/mcst_core_assertions.sv]
// Port timing checker for the control and status core.
`timescale 1ns/1ps
module mcst_core_assertions
    import mcst_pkg::*;
#(
    parameter int unsigned NUM_FLAGS = 8,
    parameter int unsigned INIT_CYC = MCST_INIT_CYC,
    parameter int unsigned PDOWN_OFF_CYC = MCST_PDOWN_OFF_CYC
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Host input pins.
    input wire logic module_reset_n,
    input wire logic module_select_n,
    input wire logic low_power_select,
    // Outputs.
    input wire logic interrupt_request_n,
    input wire logic module_present_n,
    input wire logic bus_enable,
    input wire logic low_power,
    input wire logic [NUM_FLAGS-1:0] flag_status,
    input wire logic [NUM_FLAGS-1:0] mask_status,
    input wire logic data_not_ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [31:0] wait_q;
    logic [7:0] low_q;
    logic [NUM_FLAGS-1:0] open_w;
    assign open_w = flag_status & ~mask_status;
    // The wait restarts while the reset pin is low, because a pin reset reopens init.
    always_ff @(posedge clk) begin
        if (!rstn || !data_not_ready || !module_reset_n) begin
            wait_q <= '0;
        end else begin
            wait_q <= wait_q + 32'h1;
        end
    end
    // Low run of the reset pin, kept until the core is ready again.
    always_ff @(posedge clk) begin
        if (!rstn || (module_reset_n && !data_not_ready)) begin
            low_q <= 8'h00;
        end else if (!module_reset_n && low_q != 8'hFF) begin
            low_q <= low_q + 8'h01;
        end
    end
    sequence s_sel_on;
        (!module_select_n && !data_not_ready)[*8];
    endsequence
    sequence s_sel_off;
        module_select_n[*8];
    endsequence
    property p_present; module_present_n == 1'b0; endproperty
    property p_ready_int; $fell(data_not_ready) |-> ##[0:4] !interrupt_request_n; endproperty
    property p_init; wait_q <= INIT_CYC + 12; endproperty
    property p_reset_pulse; $rose(data_not_ready) |-> low_q >= MCST_RESET_MIN_CYC; endproperty
    property p_sel_on; s_sel_on |-> bus_enable; endproperty
    property p_sel_off; s_sel_off |-> !bus_enable; endproperty
    property p_lp; low_power_select[*8] |-> low_power; endproperty
    property p_int_hold; (open_w != '0)[*2] |-> !interrupt_request_n; endproperty
    property p_int_release; $rose(interrupt_request_n) |-> open_w == '0; endproperty
    a_present: assert property (p_present) else $error("present pin not low");
    a_ready_int: assert property (p_ready_int) else $error("no interrupt after ready");
    a_init: assert property (p_init) else $error("init too long");
    a_reset_pulse: assert property (p_reset_pulse) else $error("short reset pulse taken");
    a_sel_on: assert property (p_sel_on) else $error("bus not enabled");
    a_sel_off: assert property (p_sel_off) else $error("bus still enabled");
    a_lp: assert property (p_lp) else $error("low power not entered");
    a_int_hold: assert property (p_int_hold) else $error("interrupt not held");
    a_int_release: assert property (p_int_release) else $error("interrupt released early");
endmodule : mcst_core_assertions
bind mcst_core mcst_core_assertions #(.NUM_FLAGS(NUM_FLAGS), .INIT_CYC(INIT_CYC), .PDOWN_OFF_CYC(PDOWN_OFF_CYC)) u_chk (
    .clk(clk), .rstn(rstn), .module_reset_n(module_reset_n), .module_select_n(module_select_n),
    .low_power_select(low_power_select), .interrupt_request_n(interrupt_request_n),
    .module_present_n(module_present_n), .bus_enable(bus_enable), .low_power(low_power),
    .flag_status(flag_status), .mask_status(mask_status), .data_not_ready(data_not_ready));

// [verification/mcst_host_model.sv]
// Host side bus engine model handing finished transfers to the core.
`timescale 1ns/1ps
module mcst_host_model #(
    parameter int unsigned NUM_FLAGS = 8
) (
    // Bus clock.
    input wire logic bus_clk,
    // Finished transfers.
    output logic write_done,
    output logic [NUM_FLAGS-1:0] write_mask,
    output logic write_power_down,
    output logic read_done,
    output logic [NUM_FLAGS-1:0] read_clear
);
    initial begin
        write_done = 1'b0;
        read_done = 1'b0;
        write_mask = '0;
        write_power_down = 1'b0;
        read_clear = '0;
    end
    // Values are inverted once the strobe drops so stale data cannot pass as valid.
    task automatic bus_write(input logic [NUM_FLAGS-1:0] mask, input logic pd);
        @(posedge bus_clk);
        #1;
        write_mask = mask;
        write_power_down = pd;
        write_done = 1'b1;
        @(posedge bus_clk);
        #1;
        write_done = 1'b0;
        write_mask = ~mask;
        write_power_down = ~pd;
    endtask : bus_write
    task automatic bus_read(input logic [NUM_FLAGS-1:0] clr);
        @(posedge bus_clk);
        #1;
        read_clear = clr;
        read_done = 1'b1;
        @(posedge bus_clk);
        #1;
        read_done = 1'b0;
        read_clear = ~clr;
    endtask : bus_read
endmodule : mcst_host_model

// [verification/tb.sv]
// Self-checking bench of the control and status core.
`timescale 1ns/1ps
module tb;
    localparam int unsigned NF = 8;
    localparam int unsigned INIT = 100;
    localparam int unsigned PDOFF = 50;
    logic clk, bus_clk, rstn, module_reset_n, module_select_n, low_power_select;
    logic [NF-1:0] flag_condition, write_mask, read_clear, flag_status, mask_status;
    logic write_done, write_power_down, read_done, interrupt_request_n, module_present_n;
    logic bus_enable, low_power, module_ready, data_not_ready;
    int err_total = 0;
    int num_checks = 0;
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        bus_clk = 1'b0;
        #3;
        forever #6 bus_clk = ~bus_clk;
    end
    mcst_core #(.NUM_FLAGS(NF), .INIT_CYC(INIT), .PDOWN_OFF_CYC(PDOFF)) uut (
        .clk(clk), .rstn(rstn), .bus_clk(bus_clk), .bus_rstn(rstn), .module_reset_n(module_reset_n),
        .module_select_n(module_select_n), .low_power_select(low_power_select), .flag_condition(flag_condition),
        .write_done(write_done), .write_mask(write_mask), .write_power_down(write_power_down),
        .read_done(read_done), .read_clear(read_clear), .interrupt_request_n(interrupt_request_n),
        .module_present_n(module_present_n), .bus_enable(bus_enable), .low_power(low_power),
        .module_ready(module_ready), .flag_status(flag_status), .mask_status(mask_status),
        .data_not_ready(data_not_ready));
    mcst_host_model #(.NUM_FLAGS(NF)) host (
        .bus_clk(bus_clk), .write_done(write_done), .write_mask(write_mask),
        .write_power_down(write_power_down), .read_done(read_done), .read_clear(read_clear));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    task automatic wait_init;
        int n;
        n = 0;
        while (data_not_ready !== 1'b0 && n < INIT + 20) begin
            cyc(1);
            n++;
        end
        chk(n <= INIT + 12, 1'b1);
        cyc(5);
        chk(interrupt_request_n, 1'b0);
        chk(module_ready, 1'b1);
    endtask : wait_init
    task automatic t_sel;
        chk(module_present_n, 1'b0);
        module_select_n = 1'b0;
        cyc(8);
        chk(bus_enable, 1'b1);
        module_select_n = 1'b1;
        cyc(8);
        chk(bus_enable, 1'b0);
        low_power_select = 1'b1;
        cyc(8);
        chk(low_power, 1'b1);
        low_power_select = 1'b0;
        cyc(8);
        chk(low_power, 1'b0);
    endtask : t_sel
    // Each bus step is followed by 8 cycles, enough for the crossing and the spacing.
    task automatic bus_step(input logic wr, input logic [NF-1:0] v, input logic pd);
        if (wr) begin
            host.bus_write(v, pd);
        end else begin
            host.bus_read(v);
        end
        cyc(8);
    endtask : bus_step
    task automatic t_flags;
        bus_step(1'b0, 8'hFF, 1'b0);
        chk(interrupt_request_n, 1'b1);
        flag_condition = 8'h24;
        cyc(2);
        flag_condition = 8'h00;
        cyc(6);
        chk(flag_status, 8'h24);
        chk(interrupt_request_n, 1'b0);
        bus_step(1'b1, 8'h24, 1'b0);
        chk(mask_status, 8'h24);
        chk(interrupt_request_n, 1'b1);
        bus_step(1'b1, 8'h20, 1'b0);
        chk(interrupt_request_n, 1'b0);
        bus_step(1'b0, 8'h04, 1'b0);
        chk(flag_status, 8'h20);
        chk(interrupt_request_n, 1'b1);
        bus_step(1'b1, 8'h00, 1'b0);
        chk(interrupt_request_n, 1'b0);
        bus_step(1'b0, 8'h20, 1'b0);
        chk(interrupt_request_n, 1'b1);
    endtask : t_flags
    task automatic t_pdown;
        bus_step(1'b1, 8'h00, 1'b1);
        chk(low_power, 1'b1);
        chk(module_ready, 1'b0);
        bus_step(1'b1, 8'h00, 1'b0);
        cyc(PDOFF - 18);
        chk(module_ready, 1'b0);
        cyc(20);
        chk(module_ready, 1'b1);
    endtask : t_pdown
    task automatic t_reset_pin;
        module_reset_n = 1'b0;
        cyc(20);
        module_reset_n = 1'b1;
        cyc(8);
        chk(data_not_ready, 1'b0);
        module_reset_n = 1'b0;
        cyc(60);
        chk(data_not_ready, 1'b1);
        module_reset_n = 1'b1;
        wait_init();
    endtask : t_reset_pin
    initial begin
        rstn = 1'b0;
        module_reset_n = 1'b1;
        module_select_n = 1'b1;
        low_power_select = 1'b0;
        flag_condition = 8'h00;
        cyc(10);
        rstn = 1'b1;
        wait_init();
        t_sel();
        t_flags();
        t_pdown();
        t_reset_pin();
        test_done();
    end
    initial begin
        #800000;
        err_total++;
        test_done();
    end
endmodule : tb

// [verilog/mcst_core.sv]
// Control and status core of a pluggable transceiver module: init, reset qualification, select, power, flags.
//
// Behaviour
// - Module becomes fully functional within 2000 ms of power on, plug or reset release.
// - Reset pin low counts only when held longer than 2 us; host holds it.
// - Management bus answers within 2000 ms of power on.
// - Within 2000 ms, data-not-ready bit clears and interrupt output asserts.
// - Fully functional within 2000 ms after reset pin rises.
// - Low power select high enters low power within 100 us.
// - Interrupt output goes low within 200 ms of a triggering condition.
// - Interrupt output releases within 500 us after clear-on-read of its flag.
// - Loss of signal sets its flag and asserts interrupt within 100 ms.
// - Any flag condition sets its flag and asserts interrupt within 200 ms.
// - Setting a mask stops its flag asserting interrupt within 100 ms.
// - Clearing a mask resumes its flag's interrupt within 100 ms.
// - Bus responds within 100 us after select is asserted.
// - Bus stops responding within 100 us after select is deasserted.
// - Power-down bit set enters low power within 100 ms.
// - Power-down bit cleared returns to fully functional within 300 ms.
// - Write-triggered delays count from the bus clock fall after write stop.
// - Clear-on-read delays count from the bus clock fall after read stop.
// - Fully functional shown by interrupt asserted from data-not-ready clearing.
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps

module mcst_core
    import mcst_pkg::*;
#(
    parameter int unsigned NUM_FLAGS = 8,
    parameter int unsigned INIT_CYC = MCST_INIT_CYC,
    parameter int unsigned PDOWN_OFF_CYC = MCST_PDOWN_OFF_CYC
) (
    // Control clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Clock of the two-wire bus engine, the link side.
    input wire logic bus_clk,
    input wire logic bus_rstn,
    // Host pins, asynchronous to clk.
    input wire logic module_reset_n,
    input wire logic module_select_n,
    input wire logic low_power_select,
    // Flag conditions from the module internals, asynchronous.
    input wire logic [NUM_FLAGS-1:0] flag_condition,
    // Bus engine requests in the bus clock domain, each a one-cycle pulse at the clock fall after stop.
    input wire logic write_done,
    input wire logic [NUM_FLAGS-1:0] write_mask,
    input wire logic write_power_down,
    input wire logic read_done,
    input wire logic [NUM_FLAGS-1:0] read_clear,
    // Host pins driven by the module.
    output logic interrupt_request_n,
    output logic module_present_n,
    // Status toward the internals.
    output logic bus_enable,
    output logic low_power,
    output logic module_ready,
    output logic [NUM_FLAGS-1:0] flag_status,
    output logic [NUM_FLAGS-1:0] mask_status,
    output logic data_not_ready
);

    // Parameter values that the logic cannot serve stop elaboration.
    generate
        if (NUM_FLAGS < 1 || NUM_FLAGS > 32) begin : g_bad_flags
            $error("NUM_FLAGS out of range");
        end
        if (INIT_CYC < 1 || PDOWN_OFF_CYC < 1) begin : g_bad_cycles
            $error("cycle counts must be positive");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; the first stage feeds only the second.

    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;
    logic [NUM_FLAGS-1:0] cond_s1_q;
    logic [NUM_FLAGS-1:0] cond_s2_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pin_s1_q <= 3'h3;
            pin_s2_q <= 3'h3;
        end else begin
            pin_s1_q <= {low_power_select, module_select_n, module_reset_n};
            pin_s2_q <= pin_s1_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cond_s1_q <= '0;
            cond_s2_q <= '0;
        end else begin
            cond_s1_q <= flag_condition;
            cond_s2_q <= cond_s1_q;
        end
    end

    wire logic reset_pin_n = pin_s2_q[0];
    wire logic select_pin_n = pin_s2_q[1];
    wire logic lp_pin = pin_s2_q[2];

    ////////////////////////////////////////////////////////////////////////////
    // Reset pulse qualification: short glitches are ignored.

    localparam int unsigned RW = $clog2(MCST_RESET_MIN_CYC + 2);
    localparam logic [RW-1:0] RESET_MIN = RW'(MCST_RESET_MIN_CYC);
    logic [RW-1:0] rlow_q;
    logic pin_reset_q;

    // The count must pass the minimum, so a pulse of exactly the minimum is still ignored.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rlow_q <= '0;
            pin_reset_q <= 1'b0;
        end else if (reset_pin_n) begin
            rlow_q <= '0;
            pin_reset_q <= 1'b0;
        end else if (rlow_q <= RESET_MIN) begin
            rlow_q <= rlow_q + RW'(1);
        end else begin
            pin_reset_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus side capture of host writes and clear-on-read, passed by toggle.

    logic wr_tog_q;
    logic rd_tog_q;
    logic [NUM_FLAGS-1:0] wr_mask_q;
    logic wr_pdown_q;
    logic [NUM_FLAGS-1:0] rd_clear_q;

    always_ff @(posedge bus_clk) begin
        if (!bus_rstn) begin
            wr_tog_q <= 1'b0;
            wr_mask_q <= '0;
            wr_pdown_q <= 1'b0;
        end else if (write_done) begin
            wr_tog_q <= ~wr_tog_q;
            wr_mask_q <= write_mask;
            wr_pdown_q <= write_power_down;
        end
    end

    always_ff @(posedge bus_clk) begin
        if (!bus_rstn) begin
            rd_tog_q <= 1'b0;
            rd_clear_q <= '0;
        end else if (read_done) begin
            rd_tog_q <= ~rd_tog_q;
            rd_clear_q <= read_clear;
        end
    end

    // Words are held stable between toggles, so sampling after the toggle sync is safe.
    logic [2:0] wr_sync_q;
    logic [2:0] rd_sync_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            wr_sync_q <= 3'h0;
            rd_sync_q <= 3'h0;
        end else begin
            wr_sync_q <= {wr_sync_q[1:0], wr_tog_q};
            rd_sync_q <= {rd_sync_q[1:0], rd_tog_q};
        end
    end

    wire logic wr_evt = wr_sync_q[2] ^ wr_sync_q[1];
    wire logic rd_evt = rd_sync_q[2] ^ rd_sync_q[1];

    logic [NUM_FLAGS-1:0] mask_q;
    logic pdown_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            mask_q <= '0;
        end else if (wr_evt) begin
            mask_q <= wr_mask_q;
        end
    end

    // A write always carries the full power-down bit, so it is taken with every write.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pdown_q <= 1'b0;
        end else if (wr_evt) begin
            pdown_q <= wr_pdown_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Initialisation sequencer.

    localparam int unsigned CW = $clog2((INIT_CYC > PDOWN_OFF_CYC ? INIT_CYC : PDOWN_OFF_CYC) + 1);
    mcst_state_e state_q;
    logic [CW-1:0] cnt_q;
    logic dnr_q;

    // A qualified pin reset restarts the whole sequence, as a power on would.
    always_ff @(posedge clk) begin
        if (!rstn || pin_reset_q) begin
            state_q <= MCST_ST_RESET;
            cnt_q <= '0;
        end else begin
            case (state_q)
                MCST_ST_RESET: begin
                    state_q <= MCST_ST_INIT;
                    cnt_q <= '0;
                end
                MCST_ST_INIT: begin
                    if (cnt_q >= CW'(INIT_CYC - 1)) begin
                        state_q <= MCST_ST_READY;
                    end
                    cnt_q <= cnt_q + CW'(1);
                end
                MCST_ST_READY: begin
                    cnt_q <= '0;
                    if (pdown_q) begin
                        state_q <= MCST_ST_WAKE;
                    end
                end
                MCST_ST_WAKE: begin
                    if (pdown_q) begin
                        cnt_q <= '0;
                    end else if (cnt_q >= CW'(PDOWN_OFF_CYC - 1)) begin
                        state_q <= MCST_ST_READY;
                    end else begin
                        cnt_q <= cnt_q + CW'(1);
                    end
                end
                default: begin
                    state_q <= MCST_ST_RESET;
                end
            endcase
        end
    end

    // Not-ready is set by reset and cleared once init completes.
    always_ff @(posedge clk) begin
        if (!rstn || pin_reset_q) begin
            dnr_q <= 1'b1;
        end else if (state_q == MCST_ST_READY) begin
            dnr_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flags: sticky, cleared on read, set wins over clear.

    logic [NUM_FLAGS-1:0] flag_q;
    logic ready_int_q;
    wire logic ready_evt = dnr_q && (state_q == MCST_ST_READY);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
            always_ff @(posedge clk) begin
                if (!rstn) begin
                    flag_q[gi] <= 1'b0;
                end else if (cond_s2_q[gi] && !dnr_q) begin
                    flag_q[gi] <= 1'b1;
                end else if (rd_evt && rd_clear_q[gi]) begin
                    flag_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // The ready interrupt is a latched event of its own, cleared by any clear-on-read.
    always_ff @(posedge clk) begin
        if (!rstn || pin_reset_q) begin
            ready_int_q <= 1'b0;
        end else if (ready_evt) begin
            ready_int_q <= 1'b1;
        end else if (rd_evt) begin
            ready_int_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Select gating, power state and registered outputs.

    localparam int unsigned SW = $clog2(MCST_SEL_CYC + 1);
    logic [SW-1:0] sel_cnt_q;
    logic sel_prev_q;

    // Bus enable follows the select pin after a short settle, well within the limit.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sel_cnt_q <= '0;
            sel_prev_q <= 1'b1;
        end else begin
            sel_prev_q <= select_pin_n;
            if (sel_prev_q != select_pin_n) begin
                sel_cnt_q <= '0;
            end else if (sel_cnt_q < SW'(MCST_SEL_CYC)) begin
                sel_cnt_q <= sel_cnt_q + SW'(1);
            end
        end
    end

    // The select pin counts as settled once it has held its level for two cycles.
    wire logic sel_settled = (sel_prev_q == select_pin_n) && (sel_cnt_q != '0);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            bus_enable <= 1'b0;
        end else if (state_q == MCST_ST_RESET || state_q == MCST_ST_INIT) begin
            bus_enable <= 1'b0;
        end else begin
            bus_enable <= !select_pin_n && sel_settled;
        end
    end

    // Low power is also held through init and wake so the optics stay off until ready.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            low_power <= 1'b1;
        end else begin
            low_power <= lp_pin || pdown_q || state_q != MCST_ST_READY;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            module_ready <= 1'b0;
        end else begin
            module_ready <= state_q == MCST_ST_READY && !pdown_q;
        end
    end

    // Interrupt pin is low while the ready event or any unmasked flag is pending.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            interrupt_request_n <= 1'b1;
        end else begin
            interrupt_request_n <= !(ready_int_q || |(flag_q & ~mask_q));
        end
    end

    // Present ignores every reset source, so a pin reset never hides the module.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            module_present_n <= 1'b0;
        end else begin
            module_present_n <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            flag_status <= '0;
            mask_status <= '0;
            data_not_ready <= 1'b1;
        end else begin
            flag_status <= flag_q;
            mask_status <= mask_q;
            data_not_ready <= dnr_q;
        end
    end

endmodule : mcst_core

// [verilog/mcst_pkg.sv]
// Package of timing constants and state encodings for the module control and status block.
package mcst_pkg;

    // Clock rate of the control domain in kHz.
    localparam int unsigned MCST_CLK_KHZ = 25000;

    // Documented time limits, in their printed units.
    localparam int unsigned MCST_T_INIT_MS = 2000;
    localparam int unsigned MCST_T_RESET_MIN_US = 2;
    localparam int unsigned MCST_T_LOW_POWER_SELECT_US = 100;
    localparam int unsigned MCST_T_INT_ON_MS = 200;
    localparam int unsigned MCST_T_INT_OFF_US = 500;
    localparam int unsigned MCST_T_LOS_MS = 100;
    localparam int unsigned MCST_T_MASK_MS = 100;
    localparam int unsigned MCST_T_SEL_US = 100;
    localparam int unsigned MCST_T_PDOWN_ON_MS = 100;
    localparam int unsigned MCST_T_PDOWN_OFF_MS = 300;

    // Cycle counts: least times round up, longest times round down.
    localparam int unsigned MCST_RESET_MIN_CYC = (MCST_T_RESET_MIN_US * MCST_CLK_KHZ + 999) / 1000;
    localparam int unsigned MCST_INIT_CYC = MCST_T_INIT_MS * MCST_CLK_KHZ;
    localparam int unsigned MCST_LOW_POWER_SELECT_CYC = (MCST_T_LOW_POWER_SELECT_US * MCST_CLK_KHZ) / 1000;
    localparam int unsigned MCST_SEL_CYC = (MCST_T_SEL_US * MCST_CLK_KHZ) / 1000;
    localparam int unsigned MCST_INT_OFF_CYC = (MCST_T_INT_OFF_US * MCST_CLK_KHZ) / 1000;
    localparam int unsigned MCST_PDOWN_OFF_CYC = MCST_T_PDOWN_OFF_MS * MCST_CLK_KHZ;

    // Flag bit of the monitor data not ready status, bit 0 of byte 2.
    localparam int unsigned MCST_DATA_NOT_READY_BIT = 0;

    // Initialisation sequencer states.
    typedef enum logic [1:0] {
        MCST_ST_RESET = 2'b00,
        MCST_ST_INIT = 2'b01,
        MCST_ST_READY = 2'b10,
        MCST_ST_WAKE = 2'b11
    } mcst_state_e;

endpackage : mcst_pkg
